// [design/node_id_params.svh]
// Offsets, field positions, reset value and codes of the node identity register.
// Included by the design modules; definitions only.
`ifndef NODE_ID_PARAMS_SVH
`define NODE_ID_PARAMS_SVH
`define NODE_ID_OFFSET      8'h04
`define NODE_ID_RESET       32'hFFFF0000
`define SEG_LSB             0
`define SEG_MSB             9
`define STN_LSB             10
`define STN_MSB             15
`define TREE_TOP_BIT        16
`define REPLY_LSB           23
`define REPLY_MSB           27
`define FRESH_BIT           31
`define SEG_BROADCAST       10'h3FF
`define STN_BROADCAST       6'h3F
`define REPLY_TIMEOUT       5'h10
`define REPLY_PKT_ERROR     5'h13
`define REG_READ_MASK       32'hFF81FFFF
`endif

// [design/node_id_pkg.sv]
// Types shared by the node identity register modules.
// Assumes the constants header is on the include path.
package node_id_pkg;
	typedef logic [9:0] seg_id_t;
	typedef logic [5:0] stn_id_t;
	typedef logic [4:0] reply_code_t;
	typedef enum logic [1:0]
	{
		RPL_NONE    = 2'b00,
		RPL_ACK     = 2'b01,
		RPL_TIMEOUT = 2'b10,
		RPL_PKTERR  = 2'b11
	} reply_kind_t;
endpackage

// [design/node_id_if.sv]
// Carries the programmed identity between the register and the address filter.
// Assumes one clock domain; no timing of its own.
`timescale 1ns/1ps
interface node_id_if;
	node_id_pkg::seg_id_t seg_id;
	node_id_pkg::stn_id_t stn_id;
	logic                 id_valid;
	modport owner  (output seg_id, output stn_id, output id_valid);
	modport filter (input seg_id, input stn_id, input id_valid);
endinterface

// [design/node_addr_filter.sv]
// Destination filter for incoming packets against the programmed identity.
// Assumes the destination fields are stable while dest_check is high.
`timescale 1ns/1ps
`include "node_id_params.svh"
module node_addr_filter
(
	node_id_if.filter           ids,
	input  wire logic           clk,
	input  wire logic           srst,
	input  wire logic           dest_check,
	input  wire logic [9:0]     dest_seg,
	input  wire logic [5:0]     dest_stn,
	output logic                accept_r
);
	logic seg_hit;
	logic stn_hit;
	logic bcast;

	// Broadcast ids match whatever is programmed
	assign seg_hit = (dest_seg == `SEG_BROADCAST) || (dest_seg == ids.seg_id);
	assign stn_hit = (dest_stn == `STN_BROADCAST) || (dest_stn == ids.stn_id);
	assign bcast   = (dest_stn == `STN_BROADCAST);

	// Own address only when the id is valid; broadcast always
	always_ff @(posedge clk)
	begin
		if (srst)
			accept_r <= 1'b0;
		else if (dest_check)
			accept_r <= seg_hit && (ids.id_valid ? stn_hit : bcast);
		else
			accept_r <= 1'b0;
	end
endmodule // node_addr_filter

// [design/reply_encoder.sv]
// Encodes the outcome of an async send into the five-bit reply code.
// Assumes at most one outcome pulse per cycle.
`timescale 1ns/1ps
`include "node_id_params.svh"
module reply_encoder
(
	input  wire node_id_pkg::reply_kind_t kind,
	input  wire logic [3:0]               ack_code,
	output node_id_pkg::reply_code_t      code
);
	// Plain acks carry a zero top bit
	always_comb
	begin
		unique case (kind)
			node_id_pkg::RPL_ACK:     code = {1'b0, ack_code};
			node_id_pkg::RPL_TIMEOUT: code = `REPLY_TIMEOUT;
			node_id_pkg::RPL_PKTERR:  code = `REPLY_PKT_ERROR;
			node_id_pkg::RPL_NONE:    code = 5'h00;
		endcase
	end
endmodule // reply_encoder

// [design/node_id_reg.sv]
// Node identity and transmit reply register at offset 04h, with address filter.
// Assumes a single-cycle host strobe interface synchronous to CLK and a PHY
// status pulse that carries station id and root flag.
//
// Overview of operation
// - Ten-bit segment id in bits 0-9 forms source address and filters input.
// - Destination segment 3FFh is accepted whatever segment id is programmed.
// - Six-bit station id in bits 10-15 used for source address and filter.
// - Destination station 3Fh is accepted whatever station id is programmed.
// - Each PHY register 0 status transfer overwrites station id and tree-top flag.
// - Read-only tree-top flag in bit 16 reads 1 when node is root.
// - Host writes update segment and station ids; both read/write, but a PHY status transfer in the same cycle wins for station id.
// - Bits 23-27 capture last reply to a packet from the async send queue.
// - Reply code is read-only unless the diagnostic write unlock bit is set.
// - Ack as 0_XXXX, timeout as 1_0000, ack packet error as 1_0011.
// - Reply-fresh bit 31 sets whenever an ack packet is received.
// - A host read of the register clears the reply-fresh bit.
// - Register resets to FFFF_0000h.
// - With station id valid accept own address, otherwise only broadcast.
`timescale 1ns/1ps
`include "node_id_params.svh"
module node_id_reg
(
	input  wire logic        CLK,
	input  wire logic        SRST,
	input  wire logic        HOST_SEL,
	input  wire logic        HOST_WR,
	input  wire logic [7:0]  HOST_ADDR,
	input  wire logic [31:0] HOST_WDATA,
	output logic      [31:0] HOST_RDATA,
	output logic             HOST_RVALID,
	input  wire logic        DIAG_FIELD_WRITE_UNLOCK,
	input  wire logic        STATION_ID_VALID,
	input  wire logic        PHY_REG0_XFER,
	input  wire logic [5:0]  PHY_ASSIGNED_ID,
	input  wire logic        PHY_ROOT,
	input  wire logic        ACK_RCVD,
	input  wire logic [3:0]  ACK_CODE,
	input  wire logic        ACK_PKT_ERROR,
	input  wire logic        ACK_TIMEOUT,
	input  wire logic        TRANSMIT_DONE_EVENT,
	input  wire logic        SEND_PENDING_NONBCAST,
	output logic             SEND_RETRY,
	output logic [15:0]      SOURCE_ADDR,
	input  wire logic        DEST_CHECK,
	input  wire logic [9:0]  DEST_SEG,
	input  wire logic [5:0]  DEST_STN,
	output logic             DEST_ACCEPT
);
	node_id_if ids ();

	node_id_pkg::seg_id_t       network_segment_id_r;
	node_id_pkg::stn_id_t       local_station_id_r;
	logic                       tree_top_r;
	node_id_pkg::reply_code_t   last_transmit_reply_code_r;
	logic                       reply_code_fresh_r;
	node_id_pkg::reply_kind_t   reply_kind;
	node_id_pkg::reply_code_t   reply_code_nxt;
	logic                       hit;
	logic                       host_wr_hit;
	logic                       host_rd_hit;
	logic                       reply_event;
	logic                       ack_packet;
	logic [31:0]                reg_value;

	localparam logic [31:0] RESET_VALUE = `NODE_ID_RESET;

	// Address decode of the host strobes
	assign hit         = HOST_SEL && (HOST_ADDR == `NODE_ID_OFFSET);
	assign host_wr_hit = hit && HOST_WR;
	assign host_rd_hit = hit && !HOST_WR;

	// Outcome classification; ack packet errors and timeouts outrank a plain ack
	assign ack_packet  = ACK_RCVD || ACK_PKT_ERROR;
	assign reply_event = ACK_RCVD || ACK_PKT_ERROR || ACK_TIMEOUT;
	always_comb
	begin
		if (ACK_PKT_ERROR)
			reply_kind = node_id_pkg::RPL_PKTERR;
		else if (ACK_TIMEOUT)
			reply_kind = node_id_pkg::RPL_TIMEOUT;
		else if (ACK_RCVD)
			reply_kind = node_id_pkg::RPL_ACK;
		else
			reply_kind = node_id_pkg::RPL_NONE;
	end

	reply_encoder u_enc
	(
		.kind     (reply_kind),
		.ack_code (ACK_CODE),
		.code     (reply_code_nxt)
	);

	// Segment id: host writes only. The reset word numbers bit 0 from the left,
	// so both ids take its top sixteen bits and come up all ones
	always_ff @(posedge CLK)
	begin
		if (SRST)
			network_segment_id_r <= RESET_VALUE[31:22];
		else if (host_wr_hit)
			network_segment_id_r <= HOST_WDATA[`SEG_MSB:`SEG_LSB];
	end

	// Station id: PHY transfer wins over a host write in the same cycle,
	// since the PHY carries the id the bus actually assigned
	always_ff @(posedge CLK)
	begin
		if (SRST)
			local_station_id_r <= RESET_VALUE[21:16];
		else if (PHY_REG0_XFER)
			local_station_id_r <= PHY_ASSIGNED_ID;
		else if (host_wr_hit)
			local_station_id_r <= HOST_WDATA[`STN_MSB:`STN_LSB];
	end

	// Tree-top flag, never host writable
	always_ff @(posedge CLK)
	begin
		if (SRST)
			tree_top_r <= 1'b0;
		else if (PHY_REG0_XFER)
			tree_top_r <= PHY_ROOT;
	end

	// Reply code: bus outcome wins over an unlocked host write
	always_ff @(posedge CLK)
	begin
		if (SRST)
			last_transmit_reply_code_r <= 5'h00;
		else if (reply_event)
			last_transmit_reply_code_r <= reply_code_nxt;
		else if (host_wr_hit && DIAG_FIELD_WRITE_UNLOCK)
			last_transmit_reply_code_r <= HOST_WDATA[`REPLY_MSB:`REPLY_LSB];
	end

	// Fresh flag: set beats the read clear so no ack is lost
	always_ff @(posedge CLK)
	begin
		if (SRST)
			reply_code_fresh_r <= 1'b0;
		else if (ack_packet)
			reply_code_fresh_r <= 1'b1;
		else if (host_rd_hit)
			reply_code_fresh_r <= 1'b0;
	end

	// Assembled view; reserved bits tie to zero
	always_comb
	begin
		reg_value                           = 32'h00000000;
		reg_value[`SEG_MSB:`SEG_LSB]        = network_segment_id_r;
		reg_value[`STN_MSB:`STN_LSB]        = local_station_id_r;
		reg_value[`TREE_TOP_BIT]            = tree_top_r;
		reg_value[`REPLY_MSB:`REPLY_LSB]    = last_transmit_reply_code_r;
		reg_value[`FRESH_BIT]               = reply_code_fresh_r;
	end

	// Read data registered one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			HOST_RDATA  <= 32'h00000000;
			HOST_RVALID <= 1'b0;
		end
		else
		begin
			HOST_RVALID <= HOST_SEL && !HOST_WR;
			HOST_RDATA  <= host_rd_hit ? (reg_value & `REG_READ_MASK) : 32'h00000000;
		end
	end

	// Arbitration loss: done without an ack packet, fresh or in the same cycle, means the packet stays queued
	always_ff @(posedge CLK)
	begin
		if (SRST)
			SEND_RETRY <= 1'b0;
		else
			SEND_RETRY <= TRANSMIT_DONE_EVENT && SEND_PENDING_NONBCAST
				&& !reply_code_fresh_r && !ack_packet;
	end

	// Source address of outgoing packets, registered for timing
	always_ff @(posedge CLK)
	begin
		if (SRST)
			SOURCE_ADDR <= {RESET_VALUE[21:16], RESET_VALUE[31:22]};
		else
			SOURCE_ADDR <= {local_station_id_r, network_segment_id_r};
	end

	// Identity handed to the filter
	assign ids.seg_id   = network_segment_id_r;
	assign ids.stn_id   = local_station_id_r;
	assign ids.id_valid = STATION_ID_VALID;

	node_addr_filter u_filt
	(
		.ids        (ids.filter),
		.clk        (CLK),
		.srst       (SRST),
		.dest_check (DEST_CHECK),
		.dest_seg   (DEST_SEG),
		.dest_stn   (DEST_STN),
		.accept_r   (DEST_ACCEPT)
	);
endmodule // node_id_reg

// [bench/node_id_reg_monitor.sv]
// Port checker of the node identity register.
// Assumes binding to node_id_reg; one clock, sync reset.
`timescale 1ns/1ps
module node_id_reg_monitor
(
	input wire logic		CLK,
	input wire logic		SRST,
	input wire logic		HOST_SEL,
	input wire logic		HOST_WR,
	input wire logic [7:0]	HOST_ADDR,
	input wire logic [31:0]	HOST_RDATA,
	input wire logic		HOST_RVALID,
	input wire logic		STATION_ID_VALID,
	input wire logic		PHY_REG0_XFER,
	input wire logic [5:0]	PHY_ASSIGNED_ID,
	input wire logic		PHY_ROOT,
	input wire logic		ACK_RCVD,
	input wire logic [3:0]	ACK_CODE,
	input wire logic		ACK_PKT_ERROR,
	input wire logic		ACK_TIMEOUT,
	input wire logic		TRANSMIT_DONE_EVENT,
	input wire logic		SEND_PENDING_NONBCAST,
	input wire logic		SEND_RETRY,
	input wire logic		DEST_CHECK,
	input wire logic [9:0]	DEST_SEG,
	input wire logic [5:0]	DEST_STN,
	input wire logic		DEST_ACCEPT
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	// Idle cycle and clean read; a status event there would race the read data
	sequence calm;
		!HOST_SEL && !ACK_RCVD && !ACK_PKT_ERROR && !ACK_TIMEOUT && !PHY_REG0_XFER;
	endsequence
	sequence rd_q;
		HOST_SEL && !HOST_WR && HOST_ADDR == 8'h04 && !ACK_RCVD && !ACK_PKT_ERROR
			&& !ACK_TIMEOUT && !PHY_REG0_XFER;
	endsequence
	AST_RSVD_ZERO: assert property (HOST_RVALID |-> (HOST_RDATA & 32'h707E0000) == 32'h0)
		else $error("reserved bits not zero");
	AST_BCAST: assert property (DEST_CHECK && DEST_SEG == 10'h3FF && DEST_STN == 6'h3F |=> DEST_ACCEPT)
		else $error("broadcast refused");
	AST_NO_ID: assert property (DEST_CHECK && !STATION_ID_VALID && DEST_STN != 6'h3F |=> !DEST_ACCEPT)
		else $error("own address taken while id invalid");
	AST_PHY_LOAD: assert property (PHY_REG0_XFER ##1 calm ##1 rd_q |=>
		HOST_RDATA[16] == $past(PHY_ROOT, 3) && HOST_RDATA[15:10] == $past(PHY_ASSIGNED_ID, 3))
		else $error("status transfer not loaded");
	AST_ACK_CAPTURE: assert property (ACK_RCVD && !ACK_PKT_ERROR && !ACK_TIMEOUT ##1 calm ##1 rd_q |=>
		HOST_RDATA[31] && HOST_RDATA[27:23] == {1'h0, $past(ACK_CODE, 3)})
		else $error("ack not captured");
	AST_TIMEOUT: assert property (ACK_TIMEOUT && !ACK_PKT_ERROR && !ACK_RCVD ##1 calm ##1 rd_q |=>
		HOST_RDATA[27:23] == 5'h10)
		else $error("timeout code wrong");
	AST_READ_CLEARS: assert property (rd_q ##1 calm ##1 rd_q |=> !HOST_RDATA[31])
		else $error("fresh flag survived a read");
	AST_RETRY: assert property (SEND_RETRY |-> $past(TRANSMIT_DONE_EVENT) &&
		$past(SEND_PENDING_NONBCAST) && !$past(ACK_RCVD))
		else $error("retry without cause");
endmodule // node_id_reg_monitor
bind node_id_reg node_id_reg_monitor node_id_reg_monitor_i (.*);

// [bench/host_model.sv]
// Host processor model on the one-cycle strobe bus.
// Assumes the read answer comes in the cycle after the strobe.
`timescale 1ns/1ps
module host_model
(
	input  wire logic			clk,
	output logic				sel = 1'h0,
	output logic				wr = 1'h0,
	output logic [7:0]			addr = 8'h00,
	output logic [31:0]			wdata = 32'h0,
	input  wire logic [31:0]	rdata,
	input  wire logic			rvalid
);
	// Released lines show the inverse, so stale values never look valid
	task idle;
		{sel, wr} = 2'h0;
		addr = ~addr;
		wdata = ~wdata;
	endtask
	// Write: one strobe cycle, no answer
	task wr32(input logic [7:0] a, input logic [31:0] v);
		@(negedge clk);
		{sel, wr, addr, wdata} = {2'h3, a, v};
		@(negedge clk);
		idle;
	endtask
	// Read: data taken in the answer cycle only
	task rd(input logic [7:0] a, output logic [31:0] v);
		@(negedge clk);
		{sel, wr, addr} = {2'h2, a};
		@(negedge clk);
		v = rvalid ? rdata : 32'hX;
		idle;
	endtask
endmodule // host_model

// [bench/tb_top.sv]
// Self-checking bench of the node identity register.
// Assumes a 10 MHz clock; inputs move on the falling edge.
`timescale 1ns/1ps
module tb_top;
	logic CLK = '0, SRST = '1, HOST_SEL, HOST_WR, HOST_RVALID, SEND_RETRY, DEST_ACCEPT;
	logic DIAG_FIELD_WRITE_UNLOCK = '0, STATION_ID_VALID = '0, PHY_REG0_XFER = '0;
	logic PHY_ROOT = '0, ACK_RCVD = '0, ACK_PKT_ERROR = '0, ACK_TIMEOUT = '0;
	logic TRANSMIT_DONE_EVENT = '0, SEND_PENDING_NONBCAST = '0, DEST_CHECK = '0;
	logic [3:0]		ACK_CODE = '0;
	logic [5:0]		PHY_ASSIGNED_ID = '0, DEST_STN = '0;
	logic [7:0]		HOST_ADDR;
	logic [9:0]		DEST_SEG = '0;
	logic [15:0]	SOURCE_ADDR;
	logic [31:0]	HOST_WDATA, HOST_RDATA, d;
	int				n_errors = 0, total_checks = 0, cyc = 0;
	node_id_reg node_id_reg_i (.*);
	host_model host_model_i (.clk(CLK), .sel(HOST_SEL), .wr(HOST_WR), .addr(HOST_ADDR),
		.wdata(HOST_WDATA), .rdata(HOST_RDATA), .rvalid(HOST_RVALID));
	initial forever #50 CLK = ~CLK;
	// Hang guard; the run needs about 120 cycles
	always @(posedge CLK)
		if (++cyc == 2000)
		begin
			n_errors++;
			results;
		end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1'h1;
		@(negedge CLK);
		s = 1'h0;
	endtask
	// Register image with segment 1C3h, station 2Ah, root set
	function logic [31:0] ex(input logic f, input logic [4:0] c);
		return {f, 3'h0, c, 6'h0, 1'h1, 16'hA9C3};
	endfunction
	task t_host;
		chk({16'h0, SOURCE_ADDR}, 32'h0000FFFF);
		host_model_i.rd(8'h04, d);
		chk(d, 32'h0000FFFF);
		host_model_i.wr32(8'h04, 32'hFFFFFFFF);
		host_model_i.rd(8'h04, d);
		chk(d, 32'h0000FFFF);
		host_model_i.wr32(8'h04, 32'h0000A5C3);
		host_model_i.rd(8'h08, d);
		chk(d, 32'h0); // unmapped
		chk({16'h0, SOURCE_ADDR}, 32'h0000A5C3);
		DIAG_FIELD_WRITE_UNLOCK = 1'h1;
		host_model_i.wr32(8'h04, 32'h0A80A5C3);
		DIAG_FIELD_WRITE_UNLOCK = 1'h0;
		host_model_i.rd(8'h04, d);
		chk(d, 32'h0A80A5C3);
	endtask
	task t_status;
		PHY_ASSIGNED_ID = 6'h2A;
		PHY_ROOT = 1'h1;
		pulse(PHY_REG0_XFER);
		host_model_i.rd(8'h04, d);
		chk(d, ex(1'h0, 5'h15));
		for (int i = 0; i < 16; i++)
		begin
			ACK_CODE = i[3:0];
			pulse(ACK_RCVD);
			host_model_i.rd(8'h04, d);
			chk(d, ex(1'h1, {1'h0, i[3:0]}));
			host_model_i.rd(8'h04, d);
			chk(d, ex(1'h0, {1'h0, i[3:0]}));
		end
		pulse(ACK_TIMEOUT);
		host_model_i.rd(8'h04, d);
		chk(d, ex(1'h0, 5'h10));
		pulse(ACK_PKT_ERROR);
		host_model_i.rd(8'h04, d);
		chk(d, ex(1'h1, 5'h13));
		// The read above cleared the fresh flag, so a bare done means lost arbitration
		SEND_PENDING_NONBCAST = 1'h1;
		pulse(TRANSMIT_DONE_EVENT);
		chk({31'h0, SEND_RETRY}, 32'h1);
		pulse(ACK_RCVD);
		pulse(TRANSMIT_DONE_EVENT);
		chk({31'h0, SEND_RETRY}, 32'h0);
	endtask
	task flt(input logic v, input logic [9:0] s, input logic [5:0] n, input logic e);
		STATION_ID_VALID = v;
		DEST_SEG = s;
		DEST_STN = n;
		pulse(DEST_CHECK);
		chk({31'h0, DEST_ACCEPT}, {31'h0, e});
	endtask
	task t_filter;
		flt(1'h1, 10'h1C3, 6'h2A, 1'h1);
		flt(1'h1, 10'h3FF, 6'h2A, 1'h1);
		flt(1'h1, 10'h1C3, 6'h3F, 1'h1);
		flt(1'h1, 10'h1C4, 6'h2A, 1'h0);
		flt(1'h1, 10'h1C3, 6'h2B, 1'h0);
		flt(1'h0, 10'h1C3, 6'h2A, 1'h0);
		flt(1'h0, 10'h3FF, 6'h3F, 1'h1);
	endtask
	task results;
		$display("Checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(negedge CLK);
		SRST = 1'h0;
		t_host;
		t_status;
		t_filter;
		results;
	end
endmodule // tb_top
